// *** hw/fpr_defines.svh ***
`ifndef FPR_DEFINES_SVH
`define FPR_DEFINES_SVH

// Register offsets.
`define FPR_OFS_FAN1_MIN 8'h64
`define FPR_OFS_FAN2_MIN 8'h65
`define FPR_OFS_FAN3_MIN 8'h66
`define FPR_OFS_RAMP_B 8'h63

// Reset values.
`define FPR_MIN_RESET 8'h80
`define FPR_RAMP_RESET 8'h00

// Field positions of the ramp control register.
`define FPR_OUT3_RATE_LSB 0
`define FPR_OUT3_ON_BIT 3
`define FPR_OUT2_RATE_LSB 4
`define FPR_OUT2_ON_BIT 7

// Increments per time slot for rate codes 0 to 7.
`define FPR_INC0 8'h01
`define FPR_INC1 8'h02
`define FPR_INC2 8'h03
`define FPR_INC3 8'h05
`define FPR_INC4 8'h08
`define FPR_INC5 8'h0C
`define FPR_INC6 8'h18
`define FPR_INC7 8'h30

// Time slot length in core clock cycles.
`define FPR_SLOT_CYCLES 32'd100000

`endif

// *** hw/fpr_pkg.sv ***
package fpr_pkg;
    typedef logic [7:0] fpr_duty_t;
    typedef logic [2:0] fpr_rate_t;
endpackage

// *** hw/fpr_ramp_if.sv ***
`timescale 1ns/1ps
interface fpr_ramp_if;
    logic on;
    logic [2:0] rate;
    logic [7:0] target;
    logic slot;
    logic [7:0] duty;
    modport ctrl (output on, output rate, output target, output slot, input duty);
    modport ramp (input on, input rate, input target, input slot, output duty);
endinterface

// *** hw/fpr_ramp.sv ***
`timescale 1ns/1ps
`include "fpr_defines.svh"
module fpr_ramp
    import fpr_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clkEn,
    fpr_ramp_if.ramp bus
);
    typedef struct packed {
        fpr_duty_t duty;
    } fpr_ramp_s;

    fpr_ramp_s state_r;
    fpr_ramp_s state_nxt;
    fpr_duty_t step;
    logic [8:0] up;

    always_comb
    begin
        unique case (bus.rate)
            3'h0: step = `FPR_INC0;
            3'h1: step = `FPR_INC1;
            3'h2: step = `FPR_INC2;
            3'h3: step = `FPR_INC3;
            3'h4: step = `FPR_INC4;
            3'h5: step = `FPR_INC5;
            3'h6: step = `FPR_INC6;
            3'h7: step = `FPR_INC7;
        endcase
        up = {1'b0, state_r.duty} + {1'b0, step};
        state_nxt = state_r;
        if (!bus.on)
        begin
            state_nxt.duty = bus.target;
        end
        else if (bus.slot)
        begin
            if (bus.target > state_r.duty)
            begin
                // Clamp at the target so the ramp never overshoots.
                state_nxt.duty = (up >= {1'b0, bus.target}) ? bus.target : up[7:0];
            end
            else if (bus.target < state_r.duty)
            begin
                state_nxt.duty = (state_r.duty - bus.target <= step) ? bus.target
                    : state_r.duty - step;
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            state_r <= '0;
        end
        else if (clkEn)
        begin
            state_r <= state_nxt;
        end
    end

    assign bus.duty = state_r.duty;
endmodule

// *** hw/fpr_top.sv ***
`timescale 1ns/1ps
`include "fpr_defines.svh"
// How it works
// - Output 3 duty moves gradually toward new targets when its smoothing is on.
// - Rate codes 0..7 give per-slot steps 1,2,3,5,8,12,24,48.
// - Bit 3 turns output 3 smoothing on; off means targets pass directly.
// - Bits 6:4 set output 2 rate with the same encoding.
// - Bit 7 turns output 2 smoothing on.
// - With the lock bit set, writes to the ramp control register are ignored.
// - Three 8-bit floor duty registers reset to 0x80.
// - Floor duty code maps linearly: 0x00 off, 0xFF full.
// - Floor duty registers are read-only in automatic mode.
module fpr_top
    import fpr_pkg::*;
#(
    parameter int SLOT_CYCLES = `FPR_SLOT_CYCLES
)
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic regWr,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    output logic [7:0] regRdata,
    input wire logic configLock,
    input wire logic autoMode,
    input wire logic [7:0] fanDrive2Target,
    input wire logic [7:0] fanDrive3Target,
    output logic [7:0] fanDrive2Duty,
    output logic [7:0] fanDrive3Duty,
    output logic [7:0] floorDuty1,
    output logic [7:0] floorDuty2,
    output logic [7:0] floorDuty3
);
    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [7:0] rampCtl;
        logic [2:0][7:0] floor;
        logic [31:0] slotCnt;
        logic slot;
        logic [7:0] rdata;
    } fpr_top_s;

    fpr_top_s state_r;
    fpr_top_s state_nxt;

    fpr_ramp_if ch2 ();
    fpr_ramp_if ch3 ();

    always_comb
    begin
        state_nxt = state_r;
        state_nxt.slot = 1'b0;
        if (state_r.slotCnt >= 32'(SLOT_CYCLES - 1))
        begin
            state_nxt.slotCnt = '0;
            state_nxt.slot = 1'b1;
        end
        else
        begin
            state_nxt.slotCnt = state_r.slotCnt + 32'd1;
        end
        if (regWr)
        begin
            if (regAddr == `FPR_OFS_RAMP_B && !configLock)
            begin
                state_nxt.rampCtl = regWdata;
            end
            if (!autoMode)
            begin
                if (regAddr == `FPR_OFS_FAN1_MIN)
                begin
                    state_nxt.floor[0] = regWdata;
                end
                if (regAddr == `FPR_OFS_FAN2_MIN)
                begin
                    state_nxt.floor[1] = regWdata;
                end
                if (regAddr == `FPR_OFS_FAN3_MIN)
                begin
                    state_nxt.floor[2] = regWdata;
                end
            end
        end
        unique case (regAddr)
            `FPR_OFS_RAMP_B: state_nxt.rdata = state_r.rampCtl;
            `FPR_OFS_FAN1_MIN: state_nxt.rdata = state_r.floor[0];
            `FPR_OFS_FAN2_MIN: state_nxt.rdata = state_r.floor[1];
            `FPR_OFS_FAN3_MIN: state_nxt.rdata = state_r.floor[2];
            default: state_nxt.rdata = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            state_r.rampCtl <= `FPR_RAMP_RESET;
            state_r.floor <= {3{`FPR_MIN_RESET}};
            state_r.slotCnt <= '0;
            state_r.slot <= 1'b0;
            state_r.rdata <= 8'h00;
        end
        else if (clkEn)
        begin
            state_r <= state_nxt;
        end
    end

    // ****************************************************************
    // Ramp channels
    // ****************************************************************
    assign ch3.on = state_r.rampCtl[`FPR_OUT3_ON_BIT];
    assign ch3.rate = state_r.rampCtl[`FPR_OUT3_RATE_LSB +: 3];
    assign ch3.target = fanDrive3Target;
    assign ch3.slot = state_r.slot;
    assign ch2.on = state_r.rampCtl[`FPR_OUT2_ON_BIT];
    assign ch2.rate = state_r.rampCtl[`FPR_OUT2_RATE_LSB +: 3];
    assign ch2.target = fanDrive2Target;
    assign ch2.slot = state_r.slot;

    fpr_ramp u_ramp2 (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .clkEn(clkEn),
        .bus(ch2)
    );

    fpr_ramp u_ramp3 (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .clkEn(clkEn),
        .bus(ch3)
    );

    assign fanDrive2Duty = ch2.duty;
    assign fanDrive3Duty = ch3.duty;
    // Floor codes pass out unchanged; the modulator maps them linearly.
    assign floorDuty1 = state_r.floor[0];
    assign floorDuty2 = state_r.floor[1];
    assign floorDuty3 = state_r.floor[2];
    assign regRdata = state_r.rdata;
endmodule

// *** bench/fpr_checker.sv ***
`timescale 1ns/1ps
module fpr_checker (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic regWr,
    input wire logic autoMode,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic [7:0] regRdata,
    input wire logic [7:0] fanDrive2Target,
    input wire logic [7:0] fanDrive3Target,
    input wire logic [7:0] fanDrive2Duty,
    input wire logic [7:0] fanDrive3Duty,
    input wire logic [7:0] floorDuty1,
    input wire logic [7:0] floorDuty2
);
    // ***
    // Port relations.
    // ***
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    a_floor_write:
        assert property (clkEn && regWr && !autoMode && regAddr == 8'h64
            |=> floorDuty1 == $past(regWdata)) else $error("floor write lost");
    a_auto_hold:
        assert property (clkEn && autoMode |=> $stable(floorDuty2)) else $error("floor moved");
    a_read_floor:
        assert property (clkEn && regAddr == 8'h65 |=> regRdata == $past(floorDuty2))
            else $error("bad read");
    a_read_unmapped:
        assert property (clkEn && regAddr == 8'h10 |=> regRdata == 8'h00) else $error("not 0");
    a_up_no_overshoot:
        assert property (clkEn && fanDrive3Duty <= fanDrive3Target
            |=> fanDrive3Duty <= $past(fanDrive3Target)) else $error("overshoot up");
    a_down_no_overshoot:
        assert property (clkEn && fanDrive2Duty >= fanDrive2Target
            |=> fanDrive2Duty >= $past(fanDrive2Target)) else $error("overshoot down");
    a_freeze_hold:
        assert property (!clkEn |=> $stable(fanDrive2Duty) && $stable(regRdata))
            else $error("moved while frozen");
    a_read_floor_one:
        assert property (clkEn && regAddr == 8'h64 |=> regRdata == $past(floorDuty1))
            else $error("bad read");
    c_auto_write: cover property (autoMode && regWr);
    c_rise: cover property (fanDrive2Duty > $past(fanDrive2Duty));
    c_fall: cover property (fanDrive3Duty < $past(fanDrive3Duty));
endmodule
bind fpr_top fpr_checker chk_i (.core_clk, .rst_n, .clkEn, .regWr, .autoMode, .regAddr,
    .regWdata, .regRdata, .fanDrive2Target, .fanDrive3Target, .fanDrive2Duty,
    .fanDrive3Duty, .floorDuty1, .floorDuty2);

// *** bench/fan_pwm_ramp_and_min_duty_tb.sv ***
`timescale 1ns/1ps
module fan_pwm_ramp_and_min_duty_tb;
    logic core_clk = 0, rst_n = 0, clkEn = 1, regWr = 0, configLock = 0, autoMode = 0;
    logic [7:0] regAddr = 8'h00, regWdata = 8'h00, t2 = 8'h00, t3 = 8'h00;
    logic [7:0] regRdata, duty2, duty3, f1, f2, f3;
    int num_errors = 0, num_checks = 0;
    logic [7:0] inc [8] = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h08, 8'h0C, 8'h18, 8'h30};
    always #5 core_clk = ~core_clk;
    fpr_top #(.SLOT_CYCLES(4)) dut (.core_clk, .rst_n, .clkEn, .regWr, .regAddr, .regWdata,
        .regRdata, .configLock, .autoMode, .fanDrive2Target(t2), .fanDrive3Target(t3),
        .fanDrive2Duty(duty2), .fanDrive3Duty(duty3), .floorDuty1(f1), .floorDuty2(f2),
        .floorDuty3(f3));
    // ***
    // Tasks.
    // ***
    task chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        regAddr = a;
        regWdata = d;
        regWr = 1;
        @(posedge core_clk);
        #1 regWr = 0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] exp);
        regAddr = a;
        @(posedge core_clk);
        #1 chk(regRdata, exp);
    endtask
    task tally_and_finish;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task t_regs;
        rd(8'h64, 8'h80);
        rd(8'h65, 8'h80);
        rd(8'h66, 8'h80);
        chk(f3, 8'h80);
        rd(8'h63, 8'h00);
        rd(8'h10, 8'h00);
        wr(8'h64, 8'h40);
        chk(f1, 8'h40);
        rd(8'h64, 8'h40);
        wr(8'h66, 8'hFF);
        chk(f3, 8'hFF);
        autoMode = 1;
        wr(8'h65, 8'hFF);
        chk(f2, 8'h80);
        rd(8'h65, 8'h80);
        autoMode = 0;
        configLock = 1;
        wr(8'h63, 8'h88);
        rd(8'h63, 8'h00);
        configLock = 0;
        clkEn = 0;
        @(posedge core_clk);
        #1 clkEn = 1;
        $display("regs done");
    endtask
    task t_ramp(input logic [2:0] r);
        logic [7:0] p2, p3;
        int n, last2;
        wr(8'h63, 8'h00);
        t3 = 8'hC8;
        t2 = 8'h00;
        repeat (2) @(posedge core_clk);
        #1 chk(duty3, 8'hC8);
        chk(duty2, 8'h00);
        // Spin-up is not modelled here, so this write just turns smoothing on for both outputs at rate r.
        wr(8'h63, {1'b1, r, 1'b1, r});
        t2 = 8'hC8;
        t3 = 8'h00;
        last2 = -1;
        for (n = 0; n < 2000 && (duty2 !== 8'hC8 || duty3 !== 8'h00); n++)
        begin
            p2 = duty2;
            p3 = duty3;
            @(posedge core_clk);
            #1;
            if (duty2 !== p2)
            begin
                chk(duty2, p2 + inc[r] > 8'hC8 ? 8'hC8 : p2 + inc[r]);
                // Steps must be one slot apart, four cycles in this bench.
                if (last2 >= 0)
                    chk(8'(n - last2), 8'h04);
                last2 = n;
            end
            if (duty3 !== p3) chk(duty3, p3 < inc[r] ? 8'h00 : p3 - inc[r]);
        end
        if (n == 2000)
        begin
            num_errors++;
            tally_and_finish();
        end
        $display("ramp %0d done", r);
    endtask
    initial
    begin
        repeat (3) @(posedge core_clk);
        #1 rst_n = 1;
        t_regs();
        for (int r = 0; r < 8; r++)
            t_ramp(r[2:0]);
        tally_and_finish();
    end
endmodule
